// >>> logic/sdac_ctrl.sv
`timescale 1ns/10ps
module sdac_ctrl
  import sdac_pkg::*;
#(
  parameter int CLK_PER_SAMPLE = SAMPLE_DIV,
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [CFG_W-1:0] converter_config,
  input wire logic modulator_bit,
  input wire logic event_clear,
  input wire logic result_ready,
  output logic modulator_enable,
  output logic modulator_sample,
  output logic dither_enable,
  output logic [SEL_W-1:0] mux_source,
  output logic mux_differential,
  output logic mux_supply,
  output logic mux_calibration,
  output logic select_invalid,
  output logic [RESULT_W-1:0] conversion_result,
  output logic conversion_done_event,
  output logic result_valid,
  output logic [RESULT_W-1:0] result_data
);

  sdac_state_s state_r;
  sdac_state_s state_nxt;
  logic tick;
  logic fifo_in_ready;
  logic en_cfg;
  logic [SEL_W-1:0] sel;
  logic [RATE_W-1:0] rate_cfg;
  logic [CNT_W-1:0] conv_len;
  logic [CNT_W-1:0] clamped;
  logic [RESULT_W-1:0] scaled;
  logic complete;

  // Configuration word fields.
  // field extraction here
  assign en_cfg = converter_config[CFG_ENABLE_BIT];
  assign sel = converter_config[SEL_LSB +: SEL_W];
  assign rate_cfg = converter_config[RATE_LSB +: RATE_W];

  sdac_tick #(
    .DIV(TICK_W'(CLK_PER_SAMPLE))
  ) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(en_cfg),
    .tick(tick)
  );

  sdac_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(state_r.push),
    .in_ready(fifo_in_ready),
    .in_data(state_r.push_data),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  always_comb begin
    state_nxt = state_r;
    conv_len = CNT_W'(CONV_MIN_SAMPLES) << state_r.rate;
    // A full count of ones would overflow the field, so it saturates.
    clamped = (state_r.ones >= conv_len) ? conv_len - 1'b1 : state_r.ones;
    scaled = RESULT_W'(clamped)
             << (4'(SHIFT_MAX) - {1'b0, state_r.rate});
    complete = (state_r.st == ST_HOLD)
               && (!state_r.push || fifo_in_ready);

    state_nxt.mod_en = en_cfg;
    state_nxt.dither_en = !converter_config[CFG_DITHER_BIT];

    // Input multiplexer decode; unsafe codes fall back to ground.
    state_nxt.mux_src = sel;
    state_nxt.mux_diff = 1'b0;
    state_nxt.mux_supply = 1'b0;
    state_nxt.mux_cal = 1'b0;
    state_nxt.sel_bad = 1'b0;
    if (sel <= SEL_LAST_SINGLE) begin
      state_nxt.mux_src = sel;
    end else if (sel == SEL_PAD_SUPPLY || sel == SEL_CORE_SUPPLY) begin
      state_nxt.mux_supply = 1'b1;
    end else if (sel == SEL_GROUND || sel == SEL_REFERENCE) begin
      state_nxt.mux_cal = 1'b1;
    end else if (sel == SEL_DIFF_01 || sel == SEL_DIFF_23) begin
      state_nxt.mux_diff = 1'b1;
    end else begin
      state_nxt.mux_src = SEL_GROUND;
      state_nxt.mux_cal = 1'b1;
      state_nxt.sel_bad = 1'b1;
    end

    if (state_r.push && fifo_in_ready) begin
      state_nxt.push = 1'b0;
    end
    if (event_clear) begin
      state_nxt.done = 1'b0;
    end

    case (state_r.st)
      ST_IDLE: begin
        if (en_cfg) begin
          state_nxt.st = ST_RUN;
          state_nxt.rate = rate_cfg;
          state_nxt.samples = '0;
          state_nxt.ones = '0;
        end
      end
      ST_RUN: begin
        if (tick) begin
          state_nxt.ones = state_r.ones + CNT_W'(modulator_bit);
          state_nxt.samples = state_r.samples + 1'b1;
          if (state_r.samples == conv_len - 1'b1) begin
            state_nxt.st = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        // A full buffer holds the conversion here until space returns.
        if (complete) begin
          state_nxt.result = scaled;
          state_nxt.push = 1'b1;
          state_nxt.push_data = scaled;
          state_nxt.done = 1'b1;
          state_nxt.st = ST_RUN;
          state_nxt.rate = rate_cfg;
          state_nxt.samples = '0;
          state_nxt.ones = '0;
        end
      end
      default: begin
        state_nxt.st = ST_IDLE;
      end
    endcase

    if (!en_cfg) begin
      state_nxt.st = ST_IDLE;
      state_nxt.samples = '0;
      state_nxt.ones = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign modulator_enable = state_r.mod_en;
  assign modulator_sample = tick;
  assign dither_enable = state_r.dither_en;
  assign mux_source = state_r.mux_src;
  assign mux_differential = state_r.mux_diff;
  assign mux_supply = state_r.mux_supply;
  assign mux_calibration = state_r.mux_cal;
  assign select_invalid = state_r.sel_bad;
  assign conversion_result = state_r.result;
  assign conversion_done_event = state_r.done;

  // Checking helpers: sample spacing and samples per conversion.
  logic [TICK_W-1:0] chk_gap_r;
  logic chk_armed_r;
  logic [CNT_W:0] chk_n_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chk_gap_r <= '0;
      chk_armed_r <= 1'b0;
      chk_n_r <= '0;
    end else begin
      chk_gap_r <= (tick || !en_cfg) ? '0 : chk_gap_r + 1'b1;
      chk_armed_r <= en_cfg && (chk_armed_r || tick);
      if (state_r.st == ST_IDLE || complete) begin
        chk_n_r <= '0;
      end else if (state_r.st == ST_RUN && tick) begin
        chk_n_r <= chk_n_r + 1'b1;
      end
    end
  end

  sample_gap_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tick && chk_armed_r |-> chk_gap_r == TICK_W'(CLK_PER_SAMPLE - 1))
    else $error("sample spacing wrong");

  conv_length_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_r.st == ST_HOLD && $past(state_r.st) == ST_RUN
    |-> int'(chk_n_r) == (CONV_MIN_SAMPLES << state_r.rate))
    else $error("conversion sample count wrong");

  low_bits_zero_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    complete |=> (conversion_result
      & ~(16'hffff << (SHIFT_MAX - int'($past(state_r.rate))))) == 16'h0)
    else $error("result bits below resolution set");

  rate_seven_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    complete && state_r.rate == 3'h7 && state_r.ones == 13'h0800
    |=> conversion_result == 16'h8000)
    else $error("rate 7 midscale result wrong");

  single_map_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sel <= SEL_LAST_SINGLE |=> mux_source == $past(sel)
      && !mux_differential && !mux_supply && !mux_calibration)
    else $error("single-ended select wrong");

  diff_map_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sel == SEL_DIFF_01 || sel == SEL_DIFF_23
    |=> mux_differential && mux_source == $past(sel))
    else $error("differential select wrong");

  supply_map_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sel == SEL_PAD_SUPPLY || sel == SEL_CORE_SUPPLY
    |=> mux_supply && !mux_differential)
    else $error("supply select wrong");

  bad_sel_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sel == SEL_RESERVED || sel > SEL_DIFF_23
    |=> select_invalid && mux_source == SEL_GROUND)
    else $error("reserved select not grounded");

  enable_start_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $rose(en_cfg) |=> modulator_enable ##0 state_r.st == ST_RUN)
    else $error("conversion did not start");

  done_set_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    complete |=> conversion_done_event && state_r.push)
    else $error("done flag not raised");

  done_clear_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    event_clear && !complete |=> !conversion_done_event)
    else $error("done flag not cleared");

  result_hold_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !complete |=> $stable(conversion_result))
    else $error("result changed between completions");

  dither_off_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    converter_config[CFG_DITHER_BIT]
    |=> !dither_enable)
    else $error("dither not disabled");

  calib_map_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sel == SEL_GROUND || sel == SEL_REFERENCE
    |=> mux_calibration && !select_invalid && mux_source == $past(sel))
    else $error("calibration select wrong");

  stop_idle_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !en_cfg
    |=> state_r.st == ST_IDLE && !modulator_sample)
    else $error("disabled converter still running");

endmodule

// >>> logic/sdac_fifo.sv
`timescale 1ns/10ps
module sdac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic push;
  logic pop;

  // Storage holds DEPTH words; the output register holds one more.
  assign in_ready = (count_r != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid_r || out_ready);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        out_data_r <= mem[rd_ptr_r];
      end
      count_r <= count_r + CW'(push) - CW'(pop);
      if (pop) begin
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

endmodule

// >>> logic/sdac_pkg.sv
package sdac_pkg;

  // Converter configuration word layout.
  localparam int CFG_W = 16;
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_DITHER_BIT = 1;
  localparam int SEL_LSB = 8;
  localparam int SEL_W = 4;
  localparam int RATE_LSB = 12;
  localparam int RATE_W = 3;

  // Result layout.
  localparam int RESULT_W = 16;
  localparam int MIN_BITS = 5;
  localparam int SHIFT_MAX = RESULT_W - MIN_BITS;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

  // Input source codes.
  localparam logic [SEL_W-1:0] SEL_LAST_SINGLE = 4'h3;
  localparam logic [SEL_W-1:0] SEL_PAD_SUPPLY = 4'h4;
  localparam logic [SEL_W-1:0] SEL_CORE_SUPPLY = 4'h5;
  localparam logic [SEL_W-1:0] SEL_RESERVED = 4'h6;
  localparam logic [SEL_W-1:0] SEL_GROUND = 4'h7;
  localparam logic [SEL_W-1:0] SEL_REFERENCE = 4'h8;
  localparam logic [SEL_W-1:0] SEL_DIFF_01 = 4'h9;
  localparam logic [SEL_W-1:0] SEL_DIFF_23 = 4'ha;

  // Timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int SAMPLE_RATE_HZ = 1_000_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int CONV_MIN_TIME_US = 32;
  localparam int CONV_MAX_TIME_US = 4096;
  localparam int CONV_MIN_SAMPLES = CONV_MIN_TIME_US * SAMPLE_RATE_HZ
                                    / 1_000_000;
  localparam int CONV_MAX_SAMPLES = CONV_MAX_TIME_US * SAMPLE_RATE_HZ
                                    / 1_000_000;
  localparam int CNT_W = $clog2(CONV_MAX_SAMPLES + 1);
  localparam int TICK_W = 16;

  // Result buffer.
  localparam int FIFO_WORDS = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } sdac_state_e;

  typedef struct packed {
    sdac_state_e st;
    logic [RATE_W-1:0] rate;
    logic [CNT_W-1:0] samples;
    logic [CNT_W-1:0] ones;
    logic [RESULT_W-1:0] result;
    logic done;
    logic push;
    logic [RESULT_W-1:0] push_data;
    logic [SEL_W-1:0] mux_src;
    logic mux_diff;
    logic mux_supply;
    logic mux_cal;
    logic sel_bad;
    logic mod_en;
    logic dither_en;
  } sdac_state_s;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } sdac_tick_s;

endpackage

// >>> logic/sdac_tick.sv
`timescale 1ns/10ps
module sdac_tick
  import sdac_pkg::*;
#(
  parameter logic [TICK_W-1:0] DIV = TICK_W'(SAMPLE_DIV)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  output logic tick
);

  sdac_tick_s state_r;
  sdac_tick_s state_nxt;

  // Free counter restarts whenever the converter is off.
  always_comb begin
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    if (!run) begin
      state_nxt.cnt = '0;
    end else if (state_r.cnt == DIV - 1'b1) begin
      state_nxt.cnt = '0;
      state_nxt.tick = 1'b1;
    end else begin
      state_nxt.cnt = state_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick = state_r.tick;

endmodule

// >>> sim/sdac_ctrl_bench.sv
`timescale 1ns/10ps
module sdac_ctrl_bench;
  import sdac_pkg::*;
  localparam int CPS = 2;
  logic sys_clk;
  logic resetn;
  logic [15:0] cfg;
  logic event_clear;
  logic result_ready;
  logic [1:0] density;
  logic modulator_bit;
  logic modulator_enable;
  logic modulator_sample;
  logic dither_enable;
  logic [3:0] mux_source;
  logic mux_differential;
  logic mux_supply;
  logic mux_calibration;
  logic select_invalid;
  logic [15:0] conversion_result;
  logic conversion_done_event;
  logic result_valid;
  logic [15:0] result_data;
  int fails;
  int check_count;

  sdac_ctrl #(.CLK_PER_SAMPLE(CPS), .FIFO_DEPTH(16)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .converter_config(cfg),
    .modulator_bit(modulator_bit), .event_clear(event_clear),
    .result_ready(result_ready), .modulator_enable(modulator_enable),
    .modulator_sample(modulator_sample), .dither_enable(dither_enable),
    .mux_source(mux_source), .mux_differential(mux_differential),
    .mux_supply(mux_supply), .mux_calibration(mux_calibration),
    .select_invalid(select_invalid),
    .conversion_result(conversion_result),
    .conversion_done_event(conversion_done_event),
    .result_valid(result_valid), .result_data(result_data)
  );

  sdac_modulator_model partner (
    .sys_clk(sys_clk), .resetn(resetn),
    .modulator_enable(modulator_enable),
    .modulator_sample(modulator_sample), .density(density),
    .modulator_bit(modulator_bit)
  );

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] mk(input logic [2:0] r,
      input logic [3:0] s, input logic d, input logic e);
    return {1'h0, r, s, 6'h00, d, e};
  endfunction

  task automatic clr();
    @(posedge sys_clk);
    event_clear <= 1'h1;
    @(posedge sys_clk);
    event_clear <= 1'h0;
    #1;
  endtask

  task automatic stop();
    @(posedge sys_clk);
    cfg <= cfg & 16'hfffe;
    clr();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_done(output int p, output int c);
    p = 0;
    c = 0;
    while (conversion_done_event !== 1'h1 && c < 10000) begin
      if (modulator_sample === 1'h1) p++;
      @(posedge sys_clk);
      #1;
      c++;
    end
    if (c >= 10000) chk_bit(1'h0, 1'h1); // Done timeout.
  endtask

  task automatic run_conv(input logic [15:0] c, input logic [1:0] d,
      output int p, output int n);
    @(posedge sys_clk);
    cfg <= c;
    density <= d;
    #1;
    wait_done(p, n);
  endtask

  task automatic t_mux();
    logic bad;
    for (int s = 0; s < 16; s++) begin
      @(posedge sys_clk);
      cfg <= mk(3'h0, s[3:0], s[0], 1'h0);
      @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      bad = (s == 6) || (s > 10);
      chk_word({8'h00, mux_source, mux_differential, mux_supply,
        mux_calibration, select_invalid}, {8'h00, bad ? 4'h7 : s[3:0],
        s == 9 || s == 10, s == 4 || s == 5,
        s == 7 || s == 8 || bad, bad});
      chk_bit(dither_enable, ~s[0]); // Dither control.
    end
  endtask

  task automatic t_rates();
    int p;
    int c;
    int base;
    for (int r = 0; r < 8; r++) begin
      base = (32 << r) * CPS;
      run_conv(mk(r[2:0], 4'h0, 1'h0, 1'h1), 2'h1, p, c);
      chk_word(16'(p), 16'(32 << r)); // Sample count.
      chk_bit(c >= base && c <= base + 5, 1'h1); // Sample rate.
      chk_word(conversion_result,
        16'(((1 << (5 + r)) - 1) << (11 - r)));
      stop();
    end
    run_conv(mk(3'h1, 4'h9, 1'h1, 1'h1), 2'h2, p, c);
    chk_word(conversion_result, 16'h8000); // Half scale.
    stop();
    run_conv(mk(3'h7, 4'h8, 1'h0, 1'h1), 2'h2, p, c);
    chk_word(conversion_result, 16'h8000); // Half scale.
    stop();
  endtask

  task automatic t_hold();
    int p;
    int c;
    logic [15:0] held;
    logic same;
    run_conv(mk(3'h0, 4'h0, 1'h0, 1'h1), 2'h1, p, c);
    held = conversion_result;
    same = 1'h1;
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      if (conversion_result !== held) same = 1'h0;
    end
    chk_bit(same, 1'h1); // Result held.
    chk_bit(conversion_done_event, 1'h1); // Flag sticky.
    @(posedge sys_clk);
    density <= 2'h0;
    clr();
    chk_bit(conversion_done_event, 1'h0); // Flag cleared.
    wait_done(p, c);
    chk_bit(c <= 32 * CPS, 1'h1); // Back to back.
    clr();
    wait_done(p, c);
    chk_word(conversion_result, 16'h0000); // Updated on completion.
    stop();
  endtask

  task automatic t_fifo();
    int p;
    int c;
    int w;
    @(posedge sys_clk);
    result_ready <= 1'h0;
    run_conv(mk(3'h0, 4'h2, 1'h0, 1'h1), 2'h1, p, c);
    repeat (25 * 32 * CPS) @(posedge sys_clk);
    stop();
    @(posedge sys_clk);
    result_ready <= 1'h1;
    #1;
    w = 0;
    while (result_valid === 1'h1 && w < 40) begin
      chk_word(result_data, 16'hf800); // Stored words.
      w++;
      @(posedge sys_clk);
      #1;
    end
    chk_word(16'(w), 16'(FIFO_WORDS + 2)); // Stalled then drained.
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    fails = 0;
    check_count = 0;
    resetn = 1'h0;
    cfg = 16'h0000;
    event_clear = 1'h0;
    result_ready = 1'h1;
    density = 2'h1;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    #1;
    chk_word(conversion_result, RESULT_RST); // Reset value.
    chk_bit(conversion_done_event | result_valid, 1'h0); // Idle.
    t_mux();
    t_rates();
    t_hold();
    t_fifo();
    close_out();
  end
endmodule

// >>> sim/sdac_modulator_model.sv
`timescale 1ns/10ps
module sdac_modulator_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic modulator_enable,
  input wire logic modulator_sample,
  input wire logic [1:0] density,
  output logic modulator_bit
);
  logic phase_r;
  logic idle_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'h0;
      idle_r <= 1'h0;
    end else begin
      idle_r <= ~idle_r;
      if (!modulator_enable) begin
        phase_r <= 1'h0;
      end else if (modulator_sample) begin
        phase_r <= ~phase_r;
      end
    end
  end
  // A stopped modulator shows a toggling, meaningless bit.
  always_comb begin
    if (!modulator_enable) begin
      modulator_bit = idle_r;
    end else if (density == 2'h2) begin
      modulator_bit = phase_r;
    end else begin
      modulator_bit = density[0];
    end
  end
endmodule
